// *** shared/tddr_pkg.sv ***
// constants for the test and delay diagnostic register block
package tddr_pkg;
    localparam logic [15:0] TDDR_ADDR_DELAY  = 16'hA072;
    localparam logic [15:0] TDDR_ADDR_TEST   = 16'hA872;
    localparam logic [15:0] TDDR_ADDR_STATUS = 16'hDC72;
    localparam int          TDDR_CNT_W       = 6;
    localparam int          TDDR_FREEZE_BIT  = 6;
    localparam int          TDDR_LOCK_BIT    = 7;
    localparam logic [9:0]  TDDR_TEST_WMASK  = 10'h3FF;
    localparam logic [9:0]  TDDR_TEST_RST    = 10'h000;
    localparam int          TDDR_TDL_BIT     = 8;
    localparam int          TDDR_PLD_BIT     = 2;
    localparam int          TDDR_FIRST_ACCESS_DISABLE_BIT   = 1;
    localparam int          TDDR_LVL_BIT     = 0;
    localparam logic [5:0]  TDDR_CNT_MAX     = 6'h3F;
    localparam logic [5:0]  TDDR_CNT_RST     = 6'h00;
    localparam logic [5:0]  TDDR_MID_LIMIT   = 6'h15;
    localparam logic [5:0]  TDDR_FULL_LIMIT  = 6'h2A;
    localparam logic [1:0]  TDDR_STR_LOW     = 2'h0;
    localparam logic [1:0]  TDDR_STR_MID     = 2'h2;
    localparam logic [1:0]  TDDR_STR_FULL    = 2'h3;
    localparam logic [3:0]  TDDR_CAL_SWEEPS  = 4'h1;
endpackage

// *** hw/tddr_strength_map.sv ***
// maps a delay count onto the two-bit buffer strength code
`timescale 1ns/1ps
module tddr_strength_map
    import tddr_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    // count in, code out
    input  wire logic [5:0] count_i,
    input  wire logic       hold_i,
    output logic      [1:0] strength_o
);
    typedef struct packed {
        logic [1:0] str;
    } tddr_map_st_t;

    tddr_map_st_t st_ff;
    tddr_map_st_t nxt_st;

    function automatic logic [1:0] tddr_code(input logic [5:0] c);
        if (c < TDDR_MID_LIMIT)
            tddr_code = TDDR_STR_LOW;
        else if (c < TDDR_FULL_LIMIT)
            tddr_code = TDDR_STR_MID;
        else
            tddr_code = TDDR_STR_FULL;
    endfunction

    always_comb
    begin
        nxt_st = st_ff;
        if (!hold_i)
            nxt_st.str = tddr_code(count_i);
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign strength_o = st_ff.str;

    chk_code_never_inv: assert property (@(posedge clk_i) disable iff (!rstn_i)
        st_ff.str != 2'h1) else $error("invalid strength code");
    chk_lock_holds_str: assert property (@(posedge clk_i) disable iff (!rstn_i)
        hold_i |=> $stable(st_ff.str)) else $error("locked strength moved");
endmodule

// *** hw/tddr_regs.sv ***
// diagnostic delay line, test enable and test status registers
// Function
// - buffer strength follows the six-bit delay count in the delay register.
// - count writes take effect only while the freeze bit is one.
// - test enable at A872H; upper six bits read-only, lower ten writable.
// - secondary revision appears in test enable bits 15-12.
// - mapping register self-test results appear in bits 11 and 10.
// - bits 07-03 are factory test enables for cpu, dma and map ram tests.
// - bit 08 puts the delay line into test mode.
// - pulldown enable activates bus pulldowns during processor or full power down.
// - first-access disable turns first-access page cycles into page-miss cycles.
// - level enable lets the edge/level select take effect, else ignored.
// - read-only test status at DC72H reflects internal state.
// - status bit 15 rises once initial calibration finishes.
// - status bits 14-13 give strength: 00 low, 10 mid, 11 full.
// - remaining status bits show internal test nodes.
// - each refresh cycle steps the delay line one element unless frozen or a delay hit holds it at a count below 3FH.
// - freeze bit 06 stops calibration and holds the count.
// - strength tracks count unless the lock bit holds it.
`timescale 1ns/1ps
module tddr_regs
    import tddr_pkg::*;
#(
    parameter logic [3:0] SEC_REV = 4'h1 // arbitrary value
)
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // i/o port access
    input  wire logic [15:0] io_addr_i,
    input  wire logic [15:0] io_wdata_i,
    input  wire logic        io_wr_i,
    input  wire logic        io_rd_i,
    output logic      [15:0] io_rdata_o,
    // internal events and nodes
    input  wire logic        refresh_i,
    input  wire logic        delay_hit_i,
    input  wire logic        map_test_a_i,
    input  wire logic        map_test_b_i,
    input  wire logic [6:0]  delay_test_nodes_i,
    input  wire logic [4:0]  internal_test_nodes_i,
    input  wire logic        internal_test_node_zero_i,
    input  wire logic        cpu_power_down_i,
    input  wire logic        edge_level_sel_i,
    // controls out
    output logic      [1:0]  strength_o,
    output logic             delay_line_test_en_o,
    output logic      [4:0]  factory_test_o,
    output logic             pulldown_active_o,
    output logic             first_access_disable_o,
    output logic             level_irq_sel_o
);
    typedef struct packed {
        logic [5:0]  count;
        logic        freeze;
        logic        lock;
        logic [9:0]  test;
        logic        cal;
        logic [3:0]  sweeps;
        logic [15:0] rdata;
        logic        pld;
        logic        lvl;
        logic [1:0]  sync_a;
        logic [1:0]  sync_b;
    } tddr_st_t;

    tddr_st_t   st_ff;
    tddr_st_t   nxt_st;
    logic [1:0] str;
    logic       rd_en;

    function automatic logic tddr_hit(input logic [15:0] a,
                                      input logic [15:0] r);
        tddr_hit = (a == r);
    endfunction

    tddr_strength_map u_map (
        .clk_i      (clk_i),
        .rstn_i     (rstn_i),
        .count_i    (st_ff.count),
        .hold_i     (st_ff.lock),
        .strength_o (str)
    );

    assign rd_en = io_rd_i;

    always_comb
    begin
        nxt_st = st_ff;
        // self-test flags arrive from another domain
        nxt_st.sync_a = {st_ff.sync_a[0], map_test_a_i};
        nxt_st.sync_b = {st_ff.sync_b[0], map_test_b_i};
        // calibration stepping per refresh
        if (refresh_i && !st_ff.freeze)
        begin
            if (delay_hit_i)
                nxt_st.count = st_ff.count;
            else
                nxt_st.count = st_ff.count + 6'h01;
            if (st_ff.count == TDDR_CNT_MAX)
            begin
                nxt_st.count = TDDR_CNT_RST;
                if (st_ff.sweeps != TDDR_CAL_SWEEPS)
                    nxt_st.sweeps = st_ff.sweeps + 4'h1;
            end
            if (delay_hit_i || st_ff.sweeps == TDDR_CAL_SWEEPS)
                nxt_st.cal = 1'b1;
        end
        if (io_wr_i && tddr_hit(io_addr_i, TDDR_ADDR_DELAY))
        begin
            nxt_st.lock   = io_wdata_i[TDDR_LOCK_BIT];
            nxt_st.freeze = io_wdata_i[TDDR_FREEZE_BIT];
            if (st_ff.freeze)
                nxt_st.count = io_wdata_i[TDDR_CNT_W-1:0];
        end
        if (io_wr_i && tddr_hit(io_addr_i, TDDR_ADDR_TEST))
            nxt_st.test = io_wdata_i[9:0] & TDDR_TEST_WMASK;
        // status port writes fall through untouched
        nxt_st.pld = st_ff.test[TDDR_PLD_BIT] & cpu_power_down_i;
        nxt_st.lvl = st_ff.test[TDDR_LVL_BIT] & edge_level_sel_i;
        nxt_st.rdata = 16'h0000;
        if (rd_en)
        begin
            unique case (1'b1)
                tddr_hit(io_addr_i, TDDR_ADDR_DELAY):
                    nxt_st.rdata = {8'h00, st_ff.lock, st_ff.freeze,
                                    st_ff.count};
                tddr_hit(io_addr_i, TDDR_ADDR_TEST):
                    nxt_st.rdata = {SEC_REV, st_ff.sync_a[1],
                                    st_ff.sync_b[1], st_ff.test};
                tddr_hit(io_addr_i, TDDR_ADDR_STATUS):
                    nxt_st.rdata = {st_ff.cal, str,
                                    delay_test_nodes_i,
                                    internal_test_nodes_i,
                                    internal_test_node_zero_i};
                default:
                    nxt_st.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            st_ff      <= '0;
            st_ff.test <= TDDR_TEST_RST;
        end
        else
            st_ff <= nxt_st;
    end

    assign io_rdata_o             = st_ff.rdata;
    assign strength_o             = str;
    assign delay_line_test_en_o   = st_ff.test[TDDR_TDL_BIT];
    assign factory_test_o         = st_ff.test[7:3];
    assign pulldown_active_o      = st_ff.pld;
    assign first_access_disable_o = st_ff.test[TDDR_FIRST_ACCESS_DISABLE_BIT];
    assign level_irq_sel_o        = st_ff.lvl;

    chk_frozen_count_hold: assert property (@(posedge clk_i)
        disable iff (!rstn_i)
        st_ff.freeze && !(io_wr_i && tddr_hit(io_addr_i, TDDR_ADDR_DELAY))
        |=> $stable(st_ff.count)) else $error("frozen count moved");
    chk_unfrozen_write_ign: assert property (@(posedge clk_i)
        disable iff (!rstn_i)
        io_wr_i && tddr_hit(io_addr_i, TDDR_ADDR_DELAY) && !st_ff.freeze
        && !refresh_i |=> $stable(st_ff.count))
        else $error("count written while running");
    chk_refresh_step: assert property (@(posedge clk_i) disable iff (!rstn_i)
        refresh_i && !st_ff.freeze && !delay_hit_i && !io_wr_i
        && st_ff.count != TDDR_CNT_MAX
        |=> st_ff.count == $past(st_ff.count) + 6'h01)
        else $error("refresh did not step");
    chk_cal_sticky: assert property (@(posedge clk_i) disable iff (!rstn_i)
        st_ff.cal |=> st_ff.cal) else $error("cal dropped");
    chk_test_ro_upper: assert property (@(posedge clk_i) disable iff (!rstn_i)
        rd_en && tddr_hit(io_addr_i, TDDR_ADDR_TEST)
        |=> io_rdata_o[15:12] == SEC_REV) else $error("bad revision");
    chk_pulldown_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !st_ff.test[TDDR_PLD_BIT] |=> !pulldown_active_o)
        else $error("pulldown without enable");
    chk_level_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !st_ff.test[TDDR_LVL_BIT] |=> !level_irq_sel_o)
        else $error("level select leaked");
    chk_test_write_back: assert property (@(posedge clk_i)
        disable iff (!rstn_i)
        io_wr_i && tddr_hit(io_addr_i, TDDR_ADDR_TEST)
        |=> st_ff.test == $past(io_wdata_i[9:0]))
        else $error("test write lost");
    chk_status_rd_cal: assert property (@(posedge clk_i) disable iff (!rstn_i)
        rd_en && tddr_hit(io_addr_i, TDDR_ADDR_STATUS)
        |=> io_rdata_o[15] == $past(st_ff.cal))
        else $error("status cal wrong");
endmodule

// *** verification/tddr_regs_tb.sv ***
// self-checking bench for the test and delay diagnostic registers
`timescale 1ns/1ps
module tddr_regs_tb;
    import tddr_pkg::*;
    localparam logic [3:0] REV = 4'h5; // arbitrary value
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [15:0] io_addr_i = 16'h0000;
    logic [15:0] io_wdata_i = 16'h0000;
    logic        io_wr_i = 1'b0;
    logic        io_rd_i = 1'b0;
    logic [15:0] io_rdata_o;
    logic        refresh_i = 1'b0;
    logic        delay_hit_i = 1'b0;
    logic        map_a = 1'b0;
    logic        map_b = 1'b0;
    logic [6:0]  dtn = 7'h00;
    logic [4:0]  itn = 5'h00;
    logic        itz = 1'b0;
    logic        pd = 1'b0;
    logic        els = 1'b0;
    logic [1:0]  strength_o;
    logic        tdl_o;
    logic [4:0]  fac_o;
    logic        pld_o;
    logic        fa_o;
    logic        lvl_o;
    logic [15:0] got;
    logic [5:0]  cnt [4] = '{6'h14, 6'h15, 6'h29, 6'h2A};
    logic [1:0]  str [4] = '{2'h0, 2'h2, 2'h2, 2'h3};
    int          num_errors = 0;
    int          n_checks = 0;

    always #50 clk_i = ~clk_i;

    tddr_regs #(.SEC_REV(REV)) tddr_regs_inst (
        .clk_i(clk_i), .rstn_i(rstn_i), .io_addr_i(io_addr_i),
        .io_wdata_i(io_wdata_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
        .io_rdata_o(io_rdata_o), .refresh_i(refresh_i),
        .delay_hit_i(delay_hit_i), .map_test_a_i(map_a),
        .map_test_b_i(map_b), .delay_test_nodes_i(dtn),
        .internal_test_nodes_i(itn), .internal_test_node_zero_i(itz),
        .cpu_power_down_i(pd), .edge_level_sel_i(els),
        .strength_o(strength_o), .delay_line_test_en_o(tdl_o),
        .factory_test_o(fac_o), .pulldown_active_o(pld_o),
        .first_access_disable_o(fa_o), .level_irq_sel_o(lvl_o)
    );

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_i);
        io_addr_i  <= a;
        io_wdata_i <= d;
        io_wr_i    <= 1'b1;
        @(posedge clk_i);
        io_wr_i    <= 1'b0;
    endtask

    // read data is registered: settled just after the taking edge
    task automatic rd(input logic [15:0] a);
        @(posedge clk_i);
        io_addr_i <= a;
        io_rd_i   <= 1'b1;
        @(posedge clk_i);
        io_rd_i   <= 1'b0;
        #1;
        got = io_rdata_o;
    endtask

    task automatic check_rd(input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_ctl(input logic [10:0] exp);
        logic [10:0] c;
        c = {strength_o, tdl_o, fac_o, pld_o, fa_o, lvl_o};
        n_checks++;
        if (c !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, c, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        #5_000_000;
        num_errors++;
        report_and_stop();
    end

    initial
    begin
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        rd(TDDR_ADDR_STATUS); check_rd(16'h0000);
        rd(TDDR_ADDR_TEST); check_rd({REV, 12'h000});
        @(posedge clk_i)
        begin
            pd  <= 1'b1;
            els <= 1'b1;
        end
        wr(TDDR_ADDR_TEST, 16'hFFFF);
        rd(TDDR_ADDR_TEST); check_rd({REV, 2'b00, 10'h3FF});
        check_ctl({2'h0, 1'b1, 5'h1F, 3'b111});
        wr(TDDR_ADDR_TEST, 16'h0000);
        repeat (2) @(posedge clk_i);
        #1 check_ctl(11'h000);
        @(posedge clk_i) map_a <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(TDDR_ADDR_TEST); check_rd({REV, 2'b10, 10'h000});
        @(posedge clk_i)
        begin
            map_a <= 1'b0;
            map_b <= 1'b1;
        end
        repeat (4) @(posedge clk_i);
        rd(TDDR_ADDR_TEST); check_rd({REV, 2'b01, 10'h000});
        wr(TDDR_ADDR_DELAY, 16'h0030);
        rd(TDDR_ADDR_DELAY); check_rd(16'h0000);
        // freeze first: the count only takes writes once already frozen
        wr(TDDR_ADDR_DELAY, 16'h0040);
        for (int i = 0; i < 4; i++)
        begin
            wr(TDDR_ADDR_DELAY, {10'h001, cnt[i]});
            rd(TDDR_ADDR_DELAY); check_rd({10'h001, cnt[i]});
            rd(TDDR_ADDR_STATUS); check_rd({1'b0, str[i], 13'h0});
            check_ctl({str[i], 9'h000});
        end
        wr(TDDR_ADDR_DELAY, 16'h00D0);
        rd(TDDR_ADDR_DELAY); check_rd(16'h00D0);
        rd(TDDR_ADDR_STATUS); check_rd(16'h6000);
        wr(TDDR_ADDR_DELAY, 16'h0050);
        rd(TDDR_ADDR_STATUS); check_rd(16'h0000);
        wr(TDDR_ADDR_DELAY, 16'h0000);
        repeat (3)
        begin
            @(posedge clk_i) refresh_i <= 1'b1;
            @(posedge clk_i) refresh_i <= 1'b0;
        end
        rd(TDDR_ADDR_DELAY); check_rd(16'h0003);
        wr(TDDR_ADDR_DELAY, 16'h0040);
        @(posedge clk_i) refresh_i <= 1'b1;
        @(posedge clk_i) refresh_i <= 1'b0;
        rd(TDDR_ADDR_DELAY); check_rd(16'h0043);
        // calibration only completes on a running refresh step
        wr(TDDR_ADDR_DELAY, 16'h0000);
        @(posedge clk_i)
        begin
            dtn         <= 7'h55;
            itn         <= 5'h0A;
            itz         <= 1'b1;
            refresh_i   <= 1'b1;
            delay_hit_i <= 1'b1;
        end
        @(posedge clk_i)
        begin
            refresh_i   <= 1'b0;
            delay_hit_i <= 1'b0;
        end
        wr(TDDR_ADDR_STATUS, 16'hFFFF);
        rd(TDDR_ADDR_STATUS); check_rd({3'b100, 7'h55, 5'h0A, 1'b1});
        // reset in mid-run clears test bits and calibration
        wr(TDDR_ADDR_TEST, 16'h02AA);
        @(posedge clk_i) rstn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd(TDDR_ADDR_TEST); check_rd({REV, 2'b01, 10'h000});
        rd(TDDR_ADDR_STATUS); check_rd({3'b000, 7'h55, 5'h0A, 1'b1});
        rd(16'h1234); check_rd(16'h0000);
        report_and_stop();
    end
endmodule
